// File: include/dsp_pkg.sv
// Purpose: Constants shared by the dual-slope PWM timer block
// Assumes: 32-bit AXI4-Lite register bus, 8-bit byte addresses
// Notes:   Offsets are byte addresses of aligned 32-bit words
`default_nettype none
package dsp_pkg;
    ////////////////////////////////////////////////////////////////////////
    // Bus
    localparam int          ADDR_W        = 8;
    localparam logic [7:0]  OFF_CTRL      = 8'h00;
    localparam logic [7:0]  OFF_CMP_A     = 8'h04;
    localparam logic [7:0]  OFF_CMP_B     = 8'h08;
    localparam logic [7:0]  OFF_CAPTURE   = 8'h0c;
    localparam logic [7:0]  OFF_COUNT     = 8'h10;
    localparam logic [7:0]  OFF_STATUS    = 8'h14;
    localparam logic [7:0]  OFF_MASK      = 8'h18;
    localparam logic [7:0]  OFF_STATE     = 8'h1c;
    localparam logic [1:0]  RESP_OKAY     = 2'h0;
    localparam logic [1:0]  RESP_SLVERR   = 2'h2;
    ////////////////////////////////////////////////////////////////////////
    // Control register fields
    localparam int          CTRL_W        = 10;
    localparam int          CTRL_WGM_LSB  = 0;
    localparam int          CTRL_COMA_LSB = 4;
    localparam int          CTRL_COMB_LSB = 6;
    localparam int          CTRL_DIRA_BIT = 8;
    localparam int          CTRL_DIRB_BIT = 9;
    localparam logic [9:0]  CTRL_RST      = 10'h000;
    ////////////////////////////////////////////////////////////////////////
    // Status / mask bit positions
    localparam int          ST_OVF        = 0;
    localparam int          ST_CMPA       = 1;
    localparam int          ST_CMPB       = 2;
    localparam int          ST_CAPT       = 3;
    localparam logic [3:0]  ST_RST        = 4'h0;
    ////////////////////////////////////////////////////////////////////////
    // Waveform modes and top values
    localparam logic [3:0]  WGM_PC8       = 4'h1;
    localparam logic [3:0]  WGM_PC9       = 4'h2;
    localparam logic [3:0]  WGM_PC10      = 4'h3;
    localparam logic [3:0]  WGM_PFC_CAP   = 4'h8;
    localparam logic [3:0]  WGM_PFC_CMPA  = 4'h9;
    localparam logic [3:0]  WGM_PC_CAP    = 4'ha;
    localparam logic [3:0]  WGM_PC_CMPA   = 4'hb;
    localparam logic [15:0] TOP_8BIT      = 16'h00ff;
    localparam logic [15:0] TOP_9BIT      = 16'h01ff;
    localparam logic [15:0] TOP_10BIT     = 16'h03ff;
    localparam logic [15:0] BOTTOM        = 16'h0000;
    localparam logic [15:0] CNT_RST       = 16'h0000;
    ////////////////////////////////////////////////////////////////////////
    // Output mode codes
    localparam logic [1:0]  COM_OFF       = 2'h0;
    localparam logic [1:0]  COM_TOGGLE    = 2'h1;
    localparam logic [1:0]  COM_NONINV    = 2'h2;
    localparam logic [1:0]  COM_INV       = 2'h3;
endpackage
`default_nettype wire

// File: src/dsp_pwm_top.sv
// Purpose: Dual-slope 16-bit PWM timer with AXI4-Lite registers
// Assumes: timer_tick is a prescaled enable from logic on clk
// Notes:   clk_en low freezes every flip-flop of the block
//
// The register addresses and the AXI4-Lite slave port were decided locally.
`timescale 1ns/100ps
`default_nettype none
module dsp_pwm_top
(
    input  wire logic                      clk,
    input  wire logic                      rst,
    input  wire logic                      clk_en,
    input  wire logic                      timer_tick,
    input  wire logic [dsp_pkg::ADDR_W-1:0] s_axi_awaddr,
    input  wire logic                      s_axi_awvalid,
    output logic                           s_axi_awready,
    input  wire logic [31:0]               s_axi_wdata,
    input  wire logic [3:0]                s_axi_wstrb,
    input  wire logic                      s_axi_wvalid,
    output logic                           s_axi_wready,
    output logic [1:0]                     s_axi_bresp,
    output logic                           s_axi_bvalid,
    input  wire logic                      s_axi_bready,
    input  wire logic [dsp_pkg::ADDR_W-1:0] s_axi_araddr,
    input  wire logic                      s_axi_arvalid,
    output logic                           s_axi_arready,
    output logic [31:0]                    s_axi_rdata,
    output logic [1:0]                     s_axi_rresp,
    output logic                           s_axi_rvalid,
    input  wire logic                      s_axi_rready,
    output logic                           irq,
    output logic [1:0]                     compare_output_pins,
    output logic [1:0]                     pin_oe_n
);
    ////////////////////////////////////////////////////////////////////////
    // Functions
    function automatic logic is_pc(input logic [3:0] m);
        return (m == dsp_pkg::WGM_PC8) || (m == dsp_pkg::WGM_PC9) ||
               (m == dsp_pkg::WGM_PC10) || (m == dsp_pkg::WGM_PC_CAP) ||
               (m == dsp_pkg::WGM_PC_CMPA);
    endfunction

    function automatic logic is_pfc(input logic [3:0] m);
        return (m == dsp_pkg::WGM_PFC_CAP) || (m == dsp_pkg::WGM_PFC_CMPA);
    endfunction

    function automatic logic [15:0] fixed_top(input logic [3:0] m);
        logic [15:0] t;
        t = 16'hffff;
        if (m == dsp_pkg::WGM_PC8)
            t = dsp_pkg::TOP_8BIT;
        else if (m == dsp_pkg::WGM_PC9)
            t = dsp_pkg::TOP_9BIT;
        else if (m == dsp_pkg::WGM_PC10)
            t = dsp_pkg::TOP_10BIT;
        return t;
    endfunction

    function automatic logic [31:0] strb_merge(input logic [31:0] old,
                                               input logic [31:0] nw,
                                               input logic [3:0]  strb);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++)
        begin
            if (strb[i])
                r[i*8 +: 8] = nw[i*8 +: 8];
        end
        return r;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // State
    logic [dsp_pkg::CTRL_W-1:0] ctrl_q;
    logic [15:0]                cmp_buf_q [2];
    logic [15:0]                cmp_q     [2];
    logic [15:0]                capture_value_reg_q;
    logic [15:0]                timer_count_q;
    logic                       down_q;
    logic [1:0]                 out_q;
    logic [3:0]                 status_q;
    logic [3:0]                 mask_q;
    logic [dsp_pkg::ADDR_W-1:0] aw_addr_q;
    logic [31:0]                w_data_q;
    logic [3:0]                 w_strb_q;
    logic                       aw_got_q;
    logic                       w_got_q;
    logic                       awready_q;
    logic                       wready_q;
    logic                       bvalid_q;
    logic [1:0]                 bresp_q;
    logic                       arready_q;
    logic                       rvalid_q;
    logic [31:0]                rdata_q;
    logic [1:0]                 rresp_q;
    logic                       irq_q;
    logic [1:0]                 pins_q;
    logic [1:0]                 oe_n_q;

    ////////////////////////////////////////////////////////////////////////
    // Decode
    logic [3:0]  waveform_mode_field;
    logic [1:0]  output_mode_bits [2];
    logic        pc_mode;
    logic        pfc_mode;
    logic        dual;
    logic        fixed;
    logic [15:0] top;
    logic        tick_en;
    logic        at_top;
    logic        at_bot;
    logic        up_eff;
    logic        wr_fire;
    logic [1:0]  match;
    logic [3:0]  ev_set;
    logic [3:0]  w1c;
    logic [31:0] wr_old;
    logic [31:0] wr_new;

    assign waveform_mode_field = ctrl_q[dsp_pkg::CTRL_WGM_LSB +: 4];
    assign output_mode_bits[0] = ctrl_q[dsp_pkg::CTRL_COMA_LSB +: 2];
    assign output_mode_bits[1] = ctrl_q[dsp_pkg::CTRL_COMB_LSB +: 2];
    assign pc_mode  = is_pc(waveform_mode_field);
    assign pfc_mode = is_pfc(waveform_mode_field);
    assign dual     = pc_mode | pfc_mode;
    assign fixed    = pc_mode && (waveform_mode_field < dsp_pkg::WGM_PC_CAP);
    assign tick_en  = clk_en & timer_tick;
    assign wr_fire  = aw_got_q & w_got_q & ~bvalid_q;

    always_comb
    begin
        unique case (waveform_mode_field)
            dsp_pkg::WGM_PC_CAP,
            dsp_pkg::WGM_PFC_CAP:  top = capture_value_reg_q;
            dsp_pkg::WGM_PC_CMPA,
            dsp_pkg::WGM_PFC_CMPA: top = cmp_q[0];
            default:               top = fixed_top(waveform_mode_field);
        endcase
    end

    assign at_top = dual && !down_q && (timer_count_q >= top);
    assign at_bot = dual && (timer_count_q == dsp_pkg::BOTTOM);
    // Match at top acts as down slope, at bottom as up slope
    assign up_eff = at_bot || (!down_q && !at_top);
    assign match[0] = dual && (timer_count_q == cmp_q[0]);
    assign match[1] = dual && (timer_count_q == cmp_q[1]);

    always_comb
    begin
        ev_set = 4'h0;
        if (tick_en)
        begin
            ev_set[dsp_pkg::ST_OVF] = at_bot;
            ev_set[dsp_pkg::ST_CMPB] = match[1];
            ev_set[dsp_pkg::ST_CMPA] = match[0] ||
                (at_top && waveform_mode_field[0]
                 && !fixed);
            ev_set[dsp_pkg::ST_CAPT] = at_top && !fixed &&
                !waveform_mode_field[0];
        end
    end

    always_comb
    begin
        w1c = 4'h0;
        if (wr_fire && aw_addr_q == dsp_pkg::OFF_STATUS && w_strb_q[0])
            w1c = w_data_q[3:0];
    end

    // Current contents of the addressed register, for byte-strobe merging
    always_comb
    begin
        wr_old = 32'h00000000;
        if (aw_addr_q == dsp_pkg::OFF_CMP_A)
            wr_old[15:0] = cmp_buf_q[0];
        else if (aw_addr_q == dsp_pkg::OFF_CMP_B)
            wr_old[15:0] = cmp_buf_q[1];
        else if (aw_addr_q == dsp_pkg::OFF_CAPTURE)
            wr_old[15:0] = capture_value_reg_q;
        else if (aw_addr_q == dsp_pkg::OFF_CTRL)
            wr_old[dsp_pkg::CTRL_W-1:0] = ctrl_q;
    end

    assign wr_new = strb_merge(wr_old, w_data_q, w_strb_q);

    ////////////////////////////////////////////////////////////////////////
    // Counter
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            timer_count_q <= dsp_pkg::CNT_RST;
            down_q        <= 1'b0;
        end
        else if (tick_en)
        begin
            if (!dual)
            begin
                timer_count_q <= dsp_pkg::CNT_RST;
                down_q        <= 1'b0;
            end
            else if (at_top)
            begin
                timer_count_q <= timer_count_q - 16'h0001;
                down_q        <= 1'b1;
            end
            else if (down_q && at_bot)
            begin
                timer_count_q <= timer_count_q + 16'h0001;
                down_q        <= 1'b0;
            end
            else if (down_q)
                timer_count_q <= timer_count_q - 16'h0001;
            else
                timer_count_q <= timer_count_q + 16'h0001;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Compare registers and double buffers
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            cmp_buf_q[0]        <= dsp_pkg::CNT_RST;
            cmp_buf_q[1]        <= dsp_pkg::CNT_RST;
            capture_value_reg_q <= dsp_pkg::CNT_RST;
        end
        else if (clk_en && wr_fire)
        begin
            if (aw_addr_q == dsp_pkg::OFF_CMP_A)
                cmp_buf_q[0] <= wr_new[15:0] &
                                fixed_top(waveform_mode_field);
            if (aw_addr_q == dsp_pkg::OFF_CMP_B)
                cmp_buf_q[1] <= wr_new[15:0] &
                                fixed_top(waveform_mode_field);
            if (aw_addr_q == dsp_pkg::OFF_CAPTURE)
                capture_value_reg_q <= wr_new[15:0];
        end
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            cmp_q[0] <= dsp_pkg::CNT_RST;
            cmp_q[1] <= dsp_pkg::CNT_RST;
        end
        else if (clk_en && (!dual ||
                 (tick_en && ((pc_mode && at_top) ||
                              (pfc_mode && at_bot)))))
        begin
            cmp_q[0] <= cmp_buf_q[0];
            cmp_q[1] <= cmp_buf_q[1];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Waveform outputs
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            out_q <= 2'b00;
        else if (tick_en)
        begin
            for (int c = 0; c < 2; c++)
            begin
                if (match[c])
                begin
                    if (output_mode_bits[c] == dsp_pkg::COM_NONINV)
                        out_q[c] <= !up_eff;
                    else if (output_mode_bits[c] == dsp_pkg::COM_INV)
                        out_q[c] <= up_eff;
                    else if (c == 0 && waveform_mode_field[3] &&
                             output_mode_bits[c] == dsp_pkg::COM_TOGGLE)
                        out_q[c] <= !out_q[c];
                end
            end
        end
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            pins_q <= 2'b00;
            oe_n_q <= 2'b11;
        end
        else if (clk_en)
        begin
            for (int c = 0; c < 2; c++)
            begin
                // Toggle only exists for channel A with mode bit 3 set
                pins_q[c] <= out_q[c] &&
                    ((output_mode_bits[c] > dsp_pkg::COM_TOGGLE) ||
                     (c == 0 && waveform_mode_field[3] &&
                      output_mode_bits[c] == dsp_pkg::COM_TOGGLE));
            end
            oe_n_q[0] <= !ctrl_q[dsp_pkg::CTRL_DIRA_BIT];
            oe_n_q[1] <= !ctrl_q[dsp_pkg::CTRL_DIRB_BIT];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Control, status, mask, interrupt
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            ctrl_q <= dsp_pkg::CTRL_RST;
            mask_q <= dsp_pkg::ST_RST;
        end
        else if (clk_en && wr_fire)
        begin
            if (aw_addr_q == dsp_pkg::OFF_CTRL)
                ctrl_q <= wr_new[dsp_pkg::CTRL_W-1:0];
            if (aw_addr_q == dsp_pkg::OFF_MASK && w_strb_q[0])
                mask_q <= w_data_q[3:0];
        end
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            status_q <= dsp_pkg::ST_RST;
            irq_q    <= 1'b0;
        end
        else if (clk_en)
        begin
            // A new event wins over a clear in the same cycle
            status_q <= (status_q & ~w1c) | ev_set;
            irq_q    <= |(((status_q & ~w1c) | ev_set) & mask_q);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // AXI4-Lite write channel
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            aw_addr_q <= '0;
            w_data_q  <= 32'h00000000;
            w_strb_q  <= 4'h0;
            aw_got_q  <= 1'b0;
            w_got_q   <= 1'b0;
            awready_q <= 1'b1;
            wready_q  <= 1'b1;
            bvalid_q  <= 1'b0;
            bresp_q   <= dsp_pkg::RESP_OKAY;
        end
        else if (clk_en)
        begin
            if (s_axi_awvalid && awready_q)
            begin
                aw_addr_q <= s_axi_awaddr;
                aw_got_q  <= 1'b1;
                awready_q <= 1'b0;
            end
            if (s_axi_wvalid && wready_q)
            begin
                w_data_q <= s_axi_wdata;
                w_strb_q <= s_axi_wstrb;
                w_got_q  <= 1'b1;
                wready_q <= 1'b0;
            end
            if (wr_fire)
            begin
                aw_got_q <= 1'b0;
                w_got_q  <= 1'b0;
                bvalid_q <= 1'b1;
                bresp_q  <= (aw_addr_q[1:0] != 2'h0 ||
                             aw_addr_q > dsp_pkg::OFF_STATE) ?
                            dsp_pkg::RESP_SLVERR : dsp_pkg::RESP_OKAY;
            end
            if (bvalid_q && s_axi_bready)
            begin
                bvalid_q  <= 1'b0;
                awready_q <= 1'b1;
                wready_q  <= 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // AXI4-Lite read channel
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            arready_q <= 1'b1;
            rvalid_q  <= 1'b0;
            rdata_q   <= 32'h00000000;
            rresp_q   <= dsp_pkg::RESP_OKAY;
        end
        else if (clk_en)
        begin
            if (s_axi_arvalid && arready_q)
            begin
                arready_q <= 1'b0;
                rvalid_q  <= 1'b1;
                rresp_q   <= dsp_pkg::RESP_OKAY;
                rdata_q   <= 32'h00000000;
                unique case (s_axi_araddr)
                    dsp_pkg::OFF_CTRL:    rdata_q[9:0]  <= ctrl_q;
                    dsp_pkg::OFF_CMP_A:   rdata_q[15:0] <= cmp_buf_q[0];
                    dsp_pkg::OFF_CMP_B:   rdata_q[15:0] <= cmp_buf_q[1];
                    dsp_pkg::OFF_CAPTURE: rdata_q[15:0] <= capture_value_reg_q;
                    dsp_pkg::OFF_COUNT:   rdata_q[15:0] <= timer_count_q;
                    dsp_pkg::OFF_STATUS:  rdata_q[3:0]  <= status_q;
                    dsp_pkg::OFF_MASK:    rdata_q[3:0]  <= mask_q;
                    dsp_pkg::OFF_STATE:   rdata_q[2:0]  <= {out_q, down_q};
                    default:              rresp_q       <= dsp_pkg::RESP_SLVERR;
                endcase
            end
            if (rvalid_q && s_axi_rready)
            begin
                rvalid_q  <= 1'b0;
                arready_q <= 1'b1;
            end
        end
    end

    assign s_axi_awready       = awready_q;
    assign s_axi_wready        = wready_q;
    assign s_axi_bvalid        = bvalid_q;
    assign s_axi_bresp         = bresp_q;
    assign s_axi_arready       = arready_q;
    assign s_axi_rvalid        = rvalid_q;
    assign s_axi_rdata         = rdata_q;
    assign s_axi_rresp         = rresp_q;
    assign irq                 = irq_q;
    assign compare_output_pins = pins_q;
    assign pin_oe_n            = oe_n_q;

    ////////////////////////////////////////////////////////////////////////
    // Assertions
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    AST_BOTTOM_TURN: assert property (
        tick_en && dual && down_q && timer_count_q == 16'h0000
        |=> !down_q && timer_count_q == 16'h0001)
        else $error("counter did not turn up at bottom");
    AST_FIXED_TOP: assert property (
        tick_en && waveform_mode_field == 4'h2 && !down_q &&
        timer_count_q == 16'h01ff |=> down_q && timer_count_q == 16'h01fe)
        else $error("9-bit top not honoured");
    AST_TOP_ONCE: assert property (
        tick_en && at_top |=> down_q && timer_count_q ==
        $past(timer_count_q) - 16'h0001)
        else $error("counter did not leave top after one tick");
    AST_OVF_BOT: assert property (
        tick_en && pc_mode && timer_count_q == 16'h0000
        |=> status_q[0])
        else $error("overflow flag missed at bottom");
    AST_PC_LOAD: assert property (
        tick_en && pc_mode && at_top
        |=> cmp_q[1] == $past(cmp_buf_q[1]))
        else $error("compare not loaded at top");
    AST_PFC_LOAD: assert property (
        tick_en && pfc_mode && timer_count_q == 16'h0000
        |=> cmp_q[0] == $past(cmp_buf_q[0]) && status_q[0])
        else $error("compare or overflow wrong at bottom");
    AST_PFC_TOPFLAG: assert property (
        tick_en && waveform_mode_field == 4'h8 && at_top |=> status_q[3])
        else $error("capture flag missed at top");
    AST_MATCH_B: assert property (
        tick_en && dual && timer_count_q == cmp_q[1] |=> status_q[2])
        else $error("channel B match flag missed");
    AST_NONINV_UP: assert property (
        tick_en && match[0] && output_mode_bits[0] == 2'h2 && !down_q &&
        !at_top && !at_bot |=> !out_q[0])
        else $error("non-inverted output not cleared on up match");
    AST_DIR_GATE: assert property (
        clk_en && !ctrl_q[8] |=> pin_oe_n[0])
        else $error("pin A driven while direction is input");
    AST_MASK_FIXED: assert property (
        wr_fire && clk_en && fixed_top(waveform_mode_field) == 16'h00ff
        |=> ($past(aw_addr_q) != 8'h04 || cmp_buf_q[0][15:8] == 8'h00) &&
            ($past(aw_addr_q) != 8'h08 || cmp_buf_q[1][15:8] == 8'h00))
        else $error("compare write kept bits above 8-bit resolution");
endmodule // dsp_pwm_top
`default_nettype wire

// File: tb/dsp_load.sv
// Purpose: Load seen by the two waveform pins
// Assumes: Each pin has a pull-down
// Notes:   A pin whose driver is off reads low
`timescale 1ns/100ps
`default_nettype none
module dsp_load
(
    input  wire logic [1:0] pins,
    input  wire logic [1:0] oe_n,
    output logic      [1:0] level
);
    assign level = pins & ~oe_n;
endmodule // dsp_load
`default_nettype wire

// File: tb/dsp_pwm_top_bench.sv
// Purpose: Bench for the dual-slope PWM timer
// Assumes: Ticks are stepped one at a time in the first two runs, then held high for 10 and 516 clocks
// Notes:   Top comes from compare A (3, then 5), then from capture, then the fixed 9-bit top
`timescale 1ns/100ps
`default_nettype none
module dsp_pwm_top_bench;
    logic        clk = 1'b0, rst = 1'b1, clk_en = 1'b1;
    logic        timer_tick = 1'b0, irq;
    logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
    logic [3:0]  s_axi_wstrb = 4'hf;
    logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0;
    logic        s_axi_arvalid = 1'b0, s_axi_bready = 1'b1;
    logic        s_axi_rready = 1'b1, s_axi_awready, s_axi_wready;
    logic        s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0]  s_axi_bresp, s_axi_rresp, rs, lvl;
    logic [1:0]  compare_output_pins, pin_oe_n;
    int          err_total = 0, check_count = 0, k;
    dsp_pwm_top dut (.clk(clk), .rst(rst), .clk_en(clk_en),
        .timer_tick(timer_tick), .s_axi_awaddr(s_axi_awaddr),
        .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
        .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
        .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
        .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
        .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
        .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
        .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
        .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
        .irq(irq), .compare_output_pins(compare_output_pins),
        .pin_oe_n(pin_oe_n));
    dsp_load load (.pins(compare_output_pins), .oe_n(pin_oe_n),
        .level(lvl));
    initial
    begin
        forever #25 clk = ~clk;
    end
    task automatic end_of_test;
        if (err_total == 0 && check_count > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    task automatic chk(input string n, input logic [31:0] e, s);
        check_count++;
        if (s !== e)
        begin
            err_total++;
            $display("Error %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        fork
            begin
                do @(posedge clk); while (!s_axi_awready);
                s_axi_awvalid <= 1'b0;
            end
            begin
                do @(posedge clk); while (!s_axi_wready);
                s_axi_wvalid <= 1'b0;
            end
        join
        do @(posedge clk); while (!s_axi_bvalid);
    endtask
    task automatic rc(input string n, input logic [7:0] a,
                      input logic [31:0] e);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        do @(posedge clk); while (!s_axi_arready);
        s_axi_arvalid <= 1'b0;
        do @(posedge clk); while (!s_axi_rvalid);
        rs = s_axi_rresp;
        chk(n, e, s_axi_rdata);
    endtask
    initial
    begin
        #100us;
        err_total++;
        end_of_test;
    end
    ////////////////////////////////////////////////////////////////////
    initial
    begin
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        rc("ctrl", dsp_pkg::OFF_CTRL, 32'h0);
        chk("pins", 32'h0, {30'h0, lvl});
        wr(dsp_pkg::OFF_CTRL, 32'h1);
        wr(dsp_pkg::OFF_CMP_A, 32'h1234);
        rc("cmpa", dsp_pkg::OFF_CMP_A, 32'h34);
        wr(dsp_pkg::OFF_CTRL, 32'h0);
        wr(dsp_pkg::OFF_CMP_A, 32'h3);
        wr(dsp_pkg::OFF_CMP_B, 32'h1);
        wr(dsp_pkg::OFF_CTRL, 32'h3ab);
        for (k = 1; k < 8; k++)
        begin
            timer_tick <= 1'b1;
            @(posedge clk);
            timer_tick <= 1'b0;
            rc("count", dsp_pkg::OFF_COUNT,
               k < 4 ? k : (k < 7 ? 6 - k : 1));
            chk("pins", {30'h0, k > 5, k > 3}, {30'h0, lvl});
        end
        rc("status", dsp_pkg::OFF_STATUS, 32'h7);
        wr(dsp_pkg::OFF_MASK, 32'h1);
        @(posedge clk);
        chk("irq", 32'h1, {31'h0, irq});
        wr(dsp_pkg::OFF_STATUS, 32'h1);
        chk("irq", 32'h0, {31'h0, irq});
        rc("status", dsp_pkg::OFF_STATUS, 32'h6);
        wr(dsp_pkg::OFF_STATUS, 32'hf);
        wr(dsp_pkg::OFF_CTRL, 32'h339);
        wr(dsp_pkg::OFF_CMP_A, 32'h5);
        for (k = 1; k < 12; k++)
        begin
            timer_tick <= 1'b1;
            @(posedge clk);
            timer_tick <= 1'b0;
            rc("count", dsp_pkg::OFF_COUNT, k < 3 ? k + 1 :
               (k < 6 ? 5 - k : (k < 11 ? k - 5 : 4)));
            chk("pins", {31'h0, k < 3}, {30'h0, lvl});
        end
        rc("status", dsp_pkg::OFF_STATUS, 32'h7);
        clk_en <= 1'b0;
        timer_tick <= 1'b1;
        @(posedge clk);
        clk_en <= 1'b1;
        timer_tick <= 1'b0;
        rc("frozen", dsp_pkg::OFF_COUNT, 32'h4);
        wr(dsp_pkg::OFF_STATUS, 32'hf);
        wr(dsp_pkg::OFF_CAPTURE, 32'h5);
        wr(dsp_pkg::OFF_CTRL, 32'h8);
        timer_tick <= 1'b1;
        repeat (10) @(posedge clk);
        timer_tick <= 1'b0;
        rc("status", dsp_pkg::OFF_STATUS, 32'hf);
        wr(dsp_pkg::OFF_CTRL, 32'h2);
        timer_tick <= 1'b1;
        repeat (516) @(posedge clk);
        timer_tick <= 1'b0;
        rc("count", dsp_pkg::OFF_COUNT, 32'h1fe);
        rc("unmapped", 8'h20, 32'h0);
        chk("rresp", {30'h0, dsp_pkg::RESP_SLVERR}, {30'h0, rs});
        end_of_test;
    end
endmodule // dsp_pwm_top_bench
`default_nettype wire
